// ==== bench/measurement_trigger_control_tb_top.sv ====
// Purpose: self-checking bench of mtc_trigger
// Assumes: 50 MHz ref_clk
// Notes: strobes last one cycle
`timescale 1ns/1ps
`default_nettype none
`include "mtc_consts.svh"
module measurement_trigger_control_tb_top;
  logic ref_clk, nrst, reg_wr, reg_rd, ext_trig_n, meas_done, meas_start_ff;
  logic first_of_burst_ff, armed_ff, trig_ignored_ff, read_refused_ff, fetch_ff, to_memory_ff;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata_ff;
  logic [7:0] line_trig;
  int n_fail = 0, num_checks = 0, n_ign = 0, n_ref = 0, n_st = 0, n_fst = 0, n_fch = 0, c;
  localparam logic [3:0] CT = `MTC_REG_CTRL, CN = `MTC_REG_COUNT, DL = `MTC_REG_DELAY;
  localparam logic [3:0] AU = `MTC_REG_AUTO, SR = `MTC_REG_SOURCE, STS = `MTC_REG_STATUS;
  localparam logic [3:0] NM = `MTC_REG_SRCNAME, FN = `MTC_REG_FUNC;
  logic [3:0] srcs [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8};
  logic [31:0] nms [5] = '{`MTC_NAME_BUS, `MTC_NAME_EXT, `MTC_NAME_HOLD, `MTC_NAME_IMM,
    `MTC_NAME_TTL};
  mtc_trigger #(.CW(24), .HAS_LINES(1'b1), .SCAN_MODE(0), .BURST_LEN(1)) dut (
    .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .ext_trig_n(ext_trig_n),
    .line_trig(line_trig), .meas_done(meas_done), .meas_start_ff(meas_start_ff),
    .first_of_burst_ff(first_of_burst_ff), .armed_ff(armed_ff), .fetch_ff(fetch_ff),
    .trig_ignored_ff(trig_ignored_ff), .read_refused_ff(read_refused_ff),
    .to_memory_ff(to_memory_ff));
  mtc_far_model #(.LAT(3)) pm (.ref_clk(ref_clk), .meas_start_ff(meas_start_ff),
    .meas_done(meas_done), .ext_trig_n(ext_trig_n));
  // ==========
  // clock, pulse tally, tasks
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    n_ign <= n_ign + (trig_ignored_ff === 1'b1);
    n_ref <= n_ref + (read_refused_ff === 1'b1);
    n_st <= n_st + (meas_start_ff === 1'b1);
    n_fst <= n_fst + (first_of_burst_ff === 1'b1);
    n_fch <= n_fch + (fetch_ff === 1'b1);
  end
  task bad(input string m);
    n_fail++;
    $display("BAD %0t %s", $time, m);
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
      bad($sformatf("got %h want %h", g, e));
  endtask
  function automatic logic [31:0] cb(input int b);
    return 32'h0000_0001 << b;
  endfunction
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffff_ffff);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk(reg_rdata_ff & m, e);
  endtask
  task wst(input int lim);
    c = 0;
    while (meas_start_ff !== 1'b1 && c < lim)
    begin
      @(negedge ref_clk);
      c++;
    end
    if (c >= lim)
      bad("no start");
  endtask
  task wdn();
    for (int i = 0; i < 20 && meas_done !== 1'b1; i++)
      @(negedge ref_clk);
    chk(meas_done, 1);
  endtask
  task wup();
    for (int i = 0; i < 20 && armed_ff !== 1'b1; i++)
      @(negedge ref_clk);
    chk(armed_ff, 1);
  endtask
  task end_sim();
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #200_000;
    bad("timeout");
    end_sim();
  end
  // ==========
  // tests
  initial
  begin
    nrst = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    line_trig = 8'h00;
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(CN, 1);
    rd(AU, 1);
    rd(4'hf, 0);
    wr(CN, 0);
    rd(CN, 1);
    wr(CN, 7);
    rd(CN, 7);
    wr(CT, cb(`MTC_CMD_CNTMIN));
    rd(CN, 1);
    wr(CT, cb(`MTC_CMD_CNTMAX));
    rd(CN, `MTC_COUNT_MAX);
    wr(CT, 0);
    wr(AU, 0);
    rd(AU, 0);
    wr(AU, 1);
    wr(DL, 2);
    rd(AU, 0);
    rd(DL, 2);
    wr(FN, 2);
    wr(CT, cb(`MTC_CMD_DELMIN));
    rd(DL, `MTC_DELAY_AC_US);
    wr(FN, 0);
    rd(DL, 0);
    wr(CT, cb(`MTC_CMD_DELMAX));
    rd(DL, `MTC_DELAY_MAX);
    wr(CT, 0);
    wr(FN, 2);
    wr(AU, 1);
    rd(DL, `MTC_DELAY_AC_US);
    wr(FN, 0);
    wr(DL, 2);
    for (int i = 0; i < 5; i++)
    begin
      wr(SR, srcs[i]);
      rd(SR, srcs[i]);
      rd(NM, nms[i]);
    end
    wr(SR, 5);
    rd(SR, 8);
    wr(SR, 0);
    wr(CT, cb(`MTC_CMD_READQ));
    rd(STS, 0, 3);
    chk(n_ref, 1);
    wr(CN, 2);
    wr(CT, cb(`MTC_CMD_INIT));
    for (int k = 0; k < 2; k++)
    begin
      wup();
      wr(CT, cb(`MTC_CMD_BUSTRIG));
      wst(200);
      chk(c >= 99 && c <= 103, 1);
      wdn();
    end
    rd(STS, 0, 3);
    wr(CT, cb(`MTC_CMD_BUSTRIG));
    wr(SR, 2);
    wr(CN, 1);
    wr(CT, cb(`MTC_CMD_INIT));
    wup();
    wr(CT, cb(`MTC_CMD_BUSTRIG));
    rd(STS, 1, 3);
    wr(CT, cb(`MTC_CMD_SWTRIG));
    wst(200);
    chk(to_memory_ff, 1);
    wdn();
    rd(SR, 2);
    wr(CT, cb(`MTC_CMD_FETCH));
    wr(CT, cb(`MTC_CMD_INIT));
    wup();
    wr(CT, cb(`MTC_CMD_ABORT));
    rd(STS, 0, 3);
    wr(CT, cb(`MTC_CMD_SWTRIG));
    wr(SR, 1);
    wr(DL, 0);
    wr(CT, cb(`MTC_CMD_INIT));
    wup();
    chk(to_memory_ff, 0);
    fork
      pm.ext_pulse();
    join_none
    wst(50);
    wdn();
    wr(SR, 4'hb);
    wr(CT, cb(`MTC_CMD_INIT));
    wup();
    @(posedge ref_clk) line_trig <= 8'h08;
    wst(50);
    @(posedge ref_clk) line_trig <= 8'h00;
    wdn();
    wr(CN, 4);
    wr(CT, cb(`MTC_CMD_CONF));
    rd(SR, 3);
    rd(CN, 1);
    wr(CT, cb(`MTC_CMD_INIT));
    wst(50);
    wdn();
    wr(CT, cb(`MTC_CMD_MEAS));
    wst(50);
    wdn();
    wr(CT, cb(`MTC_CMD_READQ));
    wst(50);
    wdn();
    wr(CT, cb(`MTC_CMD_SWTRIG));
    rd(STS, 0, 3);
    chk(n_ign, 3);
    chk(n_st, 8);
    chk(n_fst, 8);
    chk(n_ref, 1);
    chk(n_fch, 1);
    end_sim();
  end
endmodule
`default_nettype wire

// ==== bench/mtc_far_model.sv ====
// Purpose: measurement engine and trigger pin model
// Assumes: one done pulse per start
// Notes: pin pulse is a clean ttl low
`timescale 1ns/1ps
`default_nettype none
module mtc_far_model #(parameter int LAT = 3)
(
  input wire logic ref_clk,
  input wire logic meas_start_ff,
  output logic meas_done,
  output logic ext_trig_n
);
  // ==========
  // engine
  int cnt = 0;
  initial
  begin
    meas_done = 1'b0;
    ext_trig_n = 1'b1;
  end
  always @(posedge ref_clk)
  begin
    meas_done <= (cnt == 1);
    if (meas_start_ff === 1'b1)
      cnt <= LAT;
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
  task ext_pulse();
    @(posedge ref_clk) ext_trig_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    ext_trig_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ==== bench/mtc_trigger_properties.sv ====
// Purpose: port assertions of mtc_trigger
// Assumes: ports of the top module only
// Notes: attached by bind at the foot
`timescale 1ns/1ps
`default_nettype none
`include "mtc_consts.svh"
module mtc_trigger_chk
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata_ff,
  input wire logic ext_trig_n,
  input wire logic [7:0] line_trig,
  input wire logic meas_done,
  input wire logic meas_start_ff,
  input wire logic first_of_burst_ff,
  input wire logic armed_ff,
  input wire logic trig_ignored_ff,
  input wire logic read_refused_ff,
  input wire logic fetch_ff,
  input wire logic to_memory_ff
);
  // ==========
  // properties
  default clocking dck @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  logic ctl;
  assign ctl = reg_wr && (reg_addr == `MTC_REG_CTRL);
  AST_IGN_SW: assert property (ctl && reg_wdata[`MTC_CMD_SWTRIG] && !armed_ff
    && !$past(reg_wr) && !$past(meas_done) && !$past(meas_done, 2) |=> trig_ignored_ff)
    else $error("sw trigger not flagged");
  AST_IGN_CAUSE: assert property (trig_ignored_ff |->
    $past(ctl && (reg_wdata[`MTC_CMD_SWTRIG] || reg_wdata[`MTC_CMD_BUSTRIG])))
    else $error("ignored flag without trigger");
  AST_FIRST: assert property (first_of_burst_ff |-> meas_start_ff)
    else $error("first flag without start");
  AST_START_ONE: assert property (meas_start_ff |=> !meas_start_ff)
    else $error("start too long");
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata_ff == 32'h0000_0000)
    else $error("read data outside slot");
  AST_SRC_NO_ARM: assert property (reg_wr && reg_addr == `MTC_REG_SOURCE && !armed_ff
    && !$past(reg_wr) && !$past(meas_done) |=> !armed_ff ##1 !armed_ff)
    else $error("source select armed");
  AST_FETCH: assert property (ctl && reg_wdata[`MTC_CMD_FETCH] |=> fetch_ff)
    else $error("fetch lost");
  AST_FETCH_CAUSE: assert property ($rose(fetch_ff) |->
    $past(ctl && reg_wdata[`MTC_CMD_FETCH]))
    else $error("fetch without command");
  AST_REFUSE_CAUSE: assert property (read_refused_ff |->
    $past(ctl && reg_wdata[`MTC_CMD_READQ]))
    else $error("refusal without query");
  cover property (meas_start_ff && first_of_burst_ff);
  cover property (trig_ignored_ff);
  cover property (read_refused_ff);
  cover property (fetch_ff);
endmodule
bind mtc_trigger mtc_trigger_chk u_chk (.ref_clk(ref_clk), .nrst(nrst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata_ff(reg_rdata_ff), .ext_trig_n(ext_trig_n), .line_trig(line_trig),
  .meas_done(meas_done), .meas_start_ff(meas_start_ff), .armed_ff(armed_ff),
  .first_of_burst_ff(first_of_burst_ff), .trig_ignored_ff(trig_ignored_ff),
  .read_refused_ff(read_refused_ff), .fetch_ff(fetch_ff), .to_memory_ff(to_memory_ff));
`default_nettype wire

// ==== hdl/mtc_consts.svh ====
// Purpose: constants of the measurement trigger controller
// Assumes: 50 MHz ref_clk
// Notes: definitions only
`ifndef MTC_CONSTS_SVH
`define MTC_CONSTS_SVH
// register offsets
`define MTC_REG_CTRL 4'h0
`define MTC_REG_COUNT 4'h1
`define MTC_REG_DELAY 4'h2
`define MTC_REG_AUTO 4'h3
`define MTC_REG_SOURCE 4'h4
`define MTC_REG_STATUS 4'h5
`define MTC_REG_DONE 4'h6
`define MTC_REG_SRCNAME 4'h7
`define MTC_REG_FUNC 4'h8
// ctrl command bits
`define MTC_CMD_INIT 0
`define MTC_CMD_ABORT 1
`define MTC_CMD_SWTRIG 2
`define MTC_CMD_BUSTRIG 3
`define MTC_CMD_CONF 4
`define MTC_CMD_MEAS 5
`define MTC_CMD_READQ 6
`define MTC_CMD_FETCH 7
`define MTC_CMD_CNTMIN 8
`define MTC_CMD_CNTMAX 9
`define MTC_CMD_DELMIN 10
`define MTC_CMD_DELMAX 11
// limits and reset values
`define MTC_COUNT_MIN 24'h00_0001
`define MTC_COUNT_MAX 24'hff_ffff
`define MTC_DELAY_MAX 24'hff_ffff
`define MTC_DELAY_AC_US 24'h07_a120
`define MTC_DELAY_ZERO 24'h00_0000
// time base
`define MTC_TICK_NS 1000
`define MTC_CLK_NS 20
`define MTC_TICK_CYC (`MTC_TICK_NS / `MTC_CLK_NS)
// source name words, up to four ascii bytes each, zero-padded in the top byte
`define MTC_NAME_BUS 32'h0042_5553
`define MTC_NAME_EXT 32'h0045_5854
`define MTC_NAME_HOLD 32'h484f_4c44
`define MTC_NAME_IMM 32'h0049_4d4d
`define MTC_NAME_TTL 32'h0054_544c
`endif

// ==== hdl/mtc_pkg.sv ====
// Purpose: types of the measurement trigger controller
// Assumes: nothing
// Notes: source codes are register values
package mtc_pkg;
  typedef enum logic [3:0] {
    MTC_SRC_BUS = 4'h0,
    MTC_SRC_EXT = 4'h1,
    MTC_SRC_HOLD = 4'h2,
    MTC_SRC_IMM = 4'h3,
    MTC_SRC_LINE = 4'h8
  } mtc_src_t;
  typedef enum logic [1:0] {
    MTC_ST_IDLE = 2'b00,
    MTC_ST_WAIT = 2'b01,
    MTC_ST_DELAY = 2'b10,
    MTC_ST_MEAS = 2'b11
  } mtc_state_t;
  typedef enum logic [1:0] {
    MTC_FN_DCV = 2'b00,
    MTC_FN_RES = 2'b01,
    MTC_FN_ACV = 2'b10
  } mtc_func_t;
endpackage

// ==== hdl/mtc_trigger.sv ====
// Purpose: trigger controller of a multimeter measurement engine
// Assumes: one 50 MHz clock; software drives the register port
// Notes: source codes 8..15 pick backplane lines 0..7
`timescale 1ns/1ps
`default_nettype none
`include "mtc_consts.svh"

module mtc_trigger
  import mtc_pkg::*;
#(
  parameter int CW = 24,
  parameter bit HAS_LINES = 1'b1,
  parameter int SCAN_MODE = 0,
  parameter int BURST_LEN = 1
)
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_ff,
  input wire logic ext_trig_n,
  input wire logic [7:0] line_trig,
  input wire logic meas_done,
  output logic meas_start_ff,
  output logic first_of_burst_ff,
  output logic armed_ff,
  output logic trig_ignored_ff,
  output logic read_refused_ff,
  output logic fetch_ff,
  output logic to_memory_ff
);

  // =====================================================
  // reset release and input synchronisers
  // =====================================================
  logic [1:0] rst_sync_ff;
  logic rst_n;
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      rst_sync_ff <= 2'b00;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];

  logic [2:0] ext_sync_ff;
  logic ext_level_ff;
  logic [7:0] line_s1_ff;
  logic [7:0] line_s2_ff;
  logic [7:0] line_s3_ff;
  logic [7:0] line_level_ff;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_sync_ff <= 3'b111;
      ext_level_ff <= 1'b1;
      line_s1_ff <= 8'h00;
      line_s2_ff <= 8'h00;
      line_s3_ff <= 8'h00;
      line_level_ff <= 8'h00;
    end
    else
    begin
      ext_sync_ff <= {ext_sync_ff[1:0], ext_trig_n};
      if (ext_sync_ff[1] == ext_sync_ff[2])
        ext_level_ff <= ext_sync_ff[2];
      line_s1_ff <= line_trig;
      line_s2_ff <= line_s1_ff;
      line_s3_ff <= line_s2_ff;
      line_level_ff <= (line_s2_ff & line_s3_ff) | (line_level_ff & (line_s2_ff | line_s3_ff));
    end
  end

  // falling edge once the agreed level drops
  logic ext_fall;
  assign ext_fall = ext_level_ff && (ext_sync_ff[1] == ext_sync_ff[2]) && !ext_sync_ff[2];

  // =====================================================
  // command decode
  // =====================================================
  logic ctrl_wr;
  logic [31:0] cmd;
  assign ctrl_wr = reg_wr && (reg_addr == `MTC_REG_CTRL);
  assign cmd = ctrl_wr ? reg_wdata : 32'h0000_0000;

  logic c_init;
  logic c_abort;
  logic c_sw;
  logic c_bus;
  logic c_conf;
  logic c_meas;
  logic c_readq;
  assign c_init = cmd[`MTC_CMD_INIT];
  assign c_abort = cmd[`MTC_CMD_ABORT];
  assign c_sw = cmd[`MTC_CMD_SWTRIG];
  assign c_bus = cmd[`MTC_CMD_BUSTRIG];
  assign c_conf = cmd[`MTC_CMD_CONF];
  assign c_meas = cmd[`MTC_CMD_MEAS];
  assign c_readq = cmd[`MTC_CMD_READQ];

  // =====================================================
  // settings
  // =====================================================
  mtc_src_t src_ff;
  mtc_func_t func_ff;
  logic [CW-1:0] count_ff;
  logic [CW-1:0] delay_ff;
  logic auto_ff;

  function automatic logic [CW-1:0] min_delay(input mtc_func_t f);
    min_delay = (f == MTC_FN_ACV) ? CW'(`MTC_DELAY_AC_US) : CW'(`MTC_DELAY_ZERO);
  endfunction

  function automatic logic src_valid(input logic [3:0] s);
    src_valid = (s <= 4'h3) || (HAS_LINES && s[3]);
  endfunction

  logic bus_or_hold;
  assign bus_or_hold = (src_ff == MTC_SRC_BUS) || (src_ff == MTC_SRC_HOLD);

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      src_ff <= MTC_SRC_IMM;
    else if (c_conf || c_meas)
      src_ff <= MTC_SRC_IMM;
    else if (reg_wr && reg_addr == `MTC_REG_SOURCE && src_valid(reg_wdata[3:0]))
      src_ff <= mtc_src_t'(reg_wdata[3:0]);
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      func_ff <= MTC_FN_DCV;
    else if (reg_wr && reg_addr == `MTC_REG_FUNC && reg_wdata[1:0] != 2'b11)
      func_ff <= mtc_func_t'(reg_wdata[1:0]);
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      count_ff <= CW'(`MTC_COUNT_MIN);
    else if (c_conf || c_meas)
      count_ff <= CW'(`MTC_COUNT_MIN);
    else if (reg_wr && reg_addr == `MTC_REG_COUNT && reg_wdata[CW-1:0] != '0)
      count_ff <= reg_wdata[CW-1:0];
  end

  logic [CW-1:0] eff_delay;
  assign eff_delay = auto_ff ? min_delay(func_ff) : delay_ff;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      delay_ff <= CW'(`MTC_DELAY_ZERO);
      auto_ff <= 1'b1;
    end
    else if (reg_wr && reg_addr == `MTC_REG_DELAY)
    begin
      delay_ff <= (reg_wdata[CW-1:0] < min_delay(func_ff)) ? min_delay(func_ff)
        : reg_wdata[CW-1:0];
      auto_ff <= 1'b0;
    end
    else if (reg_wr && reg_addr == `MTC_REG_AUTO)
      auto_ff <= reg_wdata[0];
  end

  // =====================================================
  // trigger state machine
  // =====================================================
  mtc_state_t state_ff;
  logic [CW-1:0] trig_left_ff;
  logic [CW-1:0] dly_ff;
  logic [7:0] tick_ff;
  logic [15:0] burst_ff;
  logic sw_path_ff;

  logic line_hit;
  always_comb
  begin
    line_hit = 1'b0;
    if (HAS_LINES && src_ff[3])
      line_hit = line_level_ff[src_ff[2:0]] == 1'b0 && line_s3_ff[src_ff[2:0]] == 1'b0
        && line_level_ff != 8'h00 ? 1'b0 : line_level_ff[src_ff[2:0]];
  end

  logic sw_ok;
  logic hw_trig;
  logic take_trig;
  assign sw_ok = c_sw && state_ff == MTC_ST_WAIT && bus_or_hold;
  always_comb
  begin
    case (src_ff)
      MTC_SRC_BUS: hw_trig = c_bus;
      MTC_SRC_EXT: hw_trig = ext_fall;
      MTC_SRC_HOLD: hw_trig = 1'b0;
      MTC_SRC_IMM: hw_trig = 1'b1;
      default: hw_trig = line_hit;
    endcase
  end
  assign take_trig = state_ff == MTC_ST_WAIT && (hw_trig || sw_ok);

  logic refuse_read;
  logic arm;
  assign refuse_read = c_readq && bus_or_hold;
  assign arm = c_init || c_meas || (c_readq && !bus_or_hold);

  logic tick;
  assign tick = tick_ff == 8'(`MTC_TICK_CYC - 1);

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      tick_ff <= 8'h00;
    else if (state_ff != MTC_ST_DELAY || tick)
      tick_ff <= 8'h00;
    else
      tick_ff <= tick_ff + 8'h01;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= MTC_ST_IDLE;
      trig_left_ff <= '0;
      dly_ff <= '0;
      burst_ff <= 16'h0000;
      sw_path_ff <= 1'b0;
      meas_start_ff <= 1'b0;
      first_of_burst_ff <= 1'b0;
    end
    else
    begin
      meas_start_ff <= 1'b0;
      first_of_burst_ff <= 1'b0;
      if (c_abort)
        state_ff <= MTC_ST_IDLE;
      else
        case (state_ff)
          MTC_ST_IDLE:
            if (arm)
            begin
              state_ff <= MTC_ST_WAIT;
              trig_left_ff <= count_ff;
              sw_path_ff <= 1'b0;
            end
          MTC_ST_WAIT:
            if (take_trig)
            begin
              dly_ff <= eff_delay;
              sw_path_ff <= sw_ok;
              burst_ff <= 16'(BURST_LEN);
              state_ff <= MTC_ST_DELAY;
            end
          MTC_ST_DELAY:
            if (dly_ff == '0)
            begin
              meas_start_ff <= 1'b1;
              first_of_burst_ff <= 1'b1;
              state_ff <= MTC_ST_MEAS;
            end
            else if (tick)
              dly_ff <= dly_ff - CW'(1);
          MTC_ST_MEAS:
            if (meas_done)
            begin
              if (burst_ff > 16'h0001)
              begin
                burst_ff <= burst_ff - 16'h0001;
                meas_start_ff <= 1'b1;
              end
              else if (trig_left_ff <= CW'(1))
                state_ff <= MTC_ST_IDLE;
              else
              begin
                trig_left_ff <= trig_left_ff - CW'(1);
                state_ff <= MTC_ST_WAIT;
              end
            end
          default: state_ff <= MTC_ST_IDLE;
        endcase
    end
  end

  // =====================================================
  // event outputs
  // =====================================================
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      armed_ff <= 1'b0;
      trig_ignored_ff <= 1'b0;
      read_refused_ff <= 1'b0;
      fetch_ff <= 1'b0;
      to_memory_ff <= 1'b0;
    end
    else
    begin
      armed_ff <= state_ff == MTC_ST_WAIT;
      trig_ignored_ff <= (c_sw || (c_bus && src_ff == MTC_SRC_BUS)) && !take_trig;
      read_refused_ff <= refuse_read;
      fetch_ff <= cmd[`MTC_CMD_FETCH];
      to_memory_ff <= sw_path_ff && state_ff != MTC_ST_IDLE;
    end
  end

  // =====================================================
  // register read port
  // =====================================================
  logic [31:0] src_name;
  always_comb
  begin
    case (src_ff)
      MTC_SRC_BUS: src_name = `MTC_NAME_BUS;
      MTC_SRC_EXT: src_name = `MTC_NAME_EXT;
      MTC_SRC_HOLD: src_name = `MTC_NAME_HOLD;
      MTC_SRC_IMM: src_name = `MTC_NAME_IMM;
      default: src_name = `MTC_NAME_TTL;
    endcase
  end

  // min/max query forms use the query flags of the last ctrl write
  logic [1:0] qsel_ff;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      qsel_ff <= 2'b00;
    else if (ctrl_wr)
      qsel_ff <= {reg_wdata[`MTC_CMD_CNTMAX] | reg_wdata[`MTC_CMD_DELMAX],
                  reg_wdata[`MTC_CMD_CNTMIN] | reg_wdata[`MTC_CMD_DELMIN]};
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata_ff <= 32'h0000_0000;
    else if (!reg_rd)
      reg_rdata_ff <= 32'h0000_0000;
    else if (reg_addr == `MTC_REG_COUNT)
      reg_rdata_ff <= qsel_ff[1] ? 32'(`MTC_COUNT_MAX) : qsel_ff[0] ? 32'(`MTC_COUNT_MIN)
        : 32'(count_ff);
    else if (reg_addr == `MTC_REG_DELAY)
      reg_rdata_ff <= qsel_ff[1] ? 32'(`MTC_DELAY_MAX) : qsel_ff[0] ? 32'(min_delay(func_ff))
        : 32'(eff_delay);
    else if (reg_addr == `MTC_REG_AUTO)
      reg_rdata_ff <= {31'h0000_0000, auto_ff};
    else if (reg_addr == `MTC_REG_SOURCE)
      reg_rdata_ff <= {28'h000_0000, src_ff};
    else if (reg_addr == `MTC_REG_STATUS)
      reg_rdata_ff <= {28'h000_0000, sw_path_ff, armed_ff, state_ff};
    else if (reg_addr == `MTC_REG_DONE)
      reg_rdata_ff <= 32'(trig_left_ff);
    else if (reg_addr == `MTC_REG_SRCNAME)
      reg_rdata_ff <= src_name;
    else if (reg_addr == `MTC_REG_FUNC)
      reg_rdata_ff <= {30'h0000_0000, func_ff};
    else
      reg_rdata_ff <= 32'h0000_0000;
  end

endmodule
`default_nettype wire
